//--- parallel_program_port.sv
`timescale 1ns/100ps
module parallel_program_port
   import prog_pkg::*;
(
   // Clock, reset and freeze.
   input  logic               clock,
   input  logic               reset,
   input  logic               enable,
   // Programming pins; page latch doubles as byte select one, action bit one as select two.
   input  logic               load_clock_pin,
   input  logic               load_action_bit0,
   input  logic               load_action_bit1,
   input  logic               page_latch_strobe,
   input  logic               write_strobe_n,
   input  logic               output_enable_n,
   input  logic               high_voltage_entry,
   input  prog_pkg::byte_t    data_in,
   output prog_pkg::byte_t    data_out,
   output logic               data_oe,
   output logic               ready_busy_flag,
   // Status.
   output logic               prog_mode,
   output logic               entry_failed,
   output logic               eeprom_keep_fuse
);
   typedef struct packed {
      prog_state_t state;
      logic [15:0] cnt;
      logic        sweeping;
      logic [12:0] idx;
      logic [12:0] last;
      byte_t       cmd;
      byte_t       addr_lo;
      byte_t       addr_hi;
      byte_t       data_lo;
      byte_t       data_hi;
      byte_t       fuse_low;
      byte_t       fuse_high;
      byte_t       fuse_ext;
      byte_t       lock;
      byte_t       rd_data;
      logic        rd_oe;
      logic        ready;
   } core_t;

   localparam core_t CORE_RESET = '{
      state: ST_OFF, cnt: 16'h0000, sweeping: 1'b0, idx: 13'h0000, last: 13'h0000,
      cmd: CMD_NONE, addr_lo: 8'h00, addr_hi: 8'h00, data_lo: 8'h00, data_hi: 8'h00,
      fuse_low: FUSE_LOW_RESET, fuse_high: FUSE_HIGH_RESET, fuse_ext: FUSE_EXT_RESET,
      lock: LOCK_RESET, rd_data: 8'h00, rd_oe: 1'b0, ready: 1'b1};

   // Word address of flash from the two address bytes.
   function automatic logic [12:0] flash_word_addr(input byte_t hi, input byte_t lo);
      logic [15:0] full;
      full = {hi, lo};
      return full[12:0];
   endfunction

   // Byte address of the EEPROM from the two address bytes.
   function automatic logic [8:0] ee_byte_addr(input byte_t hi, input byte_t lo);
      logic [15:0] full;
      full = {hi, lo};
      return full[8:0];
   endfunction

   pin_events_if ev ();

   pin_sampler u_sampler (
      .clock              (clock),
      .reset              (reset),
      .enable             (enable),
      .load_clock_pin     (load_clock_pin),
      .load_action_bit0   (load_action_bit0),
      .load_action_bit1   (load_action_bit1),
      .page_latch_strobe  (page_latch_strobe),
      .write_strobe_n     (write_strobe_n),
      .output_enable_n    (output_enable_n),
      .high_voltage_entry (high_voltage_entry),
      .data_in            (data_in),
      .ev                 (ev.sampler)
   );

   // Memories keep their contents through reset, as the cells they model would.
   word_t flash_mem [0:8191];
   byte_t ee_mem    [0:511];
   word_t page_buf  [0:63];
   byte_t ee_buf    [0:3];

   core_t       r_q;
   core_t       r_d;
   logic        flash_we;
   logic [12:0] flash_wa;
   word_t       flash_wd;
   logic        ee_we;
   logic [8:0]  ee_wa;
   byte_t       ee_wd;
   logic        pbuf_we;
   logic [5:0]  pbuf_wa;
   word_t       pbuf_wd;
   logic        ebuf_we;
   logic [1:0]  ebuf_wa;
   byte_t       ebuf_wd;
   logic [12:0] cur_word;
   logic [8:0]  cur_ee;
   logic        write_ok;
   logic        read_ok;
   logic        keep_ee;
   logic        in_mode;
   word_t       rd_word;
   byte_t       rd_byte;

   assign cur_word = flash_word_addr(r_q.addr_hi, r_q.addr_lo);
   assign cur_ee   = ee_byte_addr(r_q.addr_hi, r_q.addr_lo);
   assign write_ok = (r_q.lock[1:0] == LOCK_MODE_OPEN);
   assign read_ok  = (r_q.lock[1:0] != LOCK_MODE_FULL);
   assign keep_ee  = ~r_q.fuse_high[KEEP_FUSE_BIT];
   assign in_mode  = (r_q.state == ST_READY) || (r_q.state == ST_BUSY);
   assign rd_word  = flash_mem[cur_word];

   // Read path: the loaded command and the byte selects pick the byte to show.
   always_comb
   begin
      rd_byte = ERASED_BYTE;
      case (r_q.cmd)
         CMD_READ_FLASH:
            if (read_ok)
               rd_byte = ev.sel_first ? rd_word[15:8] : rd_word[7:0];
         CMD_READ_EEPROM:
            if (read_ok)
               rd_byte = ee_mem[cur_ee];
         CMD_READ_FUSE:
            case ({ev.act1, ev.sel_first})
               2'b00:   rd_byte = r_q.fuse_low;
               2'b11:   rd_byte = r_q.fuse_high;
               2'b10:   rd_byte = r_q.fuse_ext;
               default: rd_byte = r_q.lock;
            endcase
         CMD_READ_SIG:
            if (ev.sel_first)
               rd_byte = (r_q.addr_lo == 8'h00) ? CALIB_BYTE : ERASED_BYTE;
            else if (r_q.addr_lo == 8'h00)
               rd_byte = SIG_BYTE0;
            else if (r_q.addr_lo == 8'h01)
               rd_byte = SIG_BYTE1;
            else if (r_q.addr_lo == 8'h02)
               rd_byte = SIG_BYTE2;
         default:
            rd_byte = ERASED_BYTE;
      endcase
   end

   // Main sequencer: entry check, pin decoding and the busy sweep.
   always_comb
   begin
      r_d      = r_q;
      flash_we = 1'b0;
      flash_wa = r_q.idx;
      flash_wd = ERASED_WORD;
      ee_we    = 1'b0;
      ee_wa    = r_q.idx[8:0];
      ee_wd    = ERASED_BYTE;
      pbuf_we  = 1'b0;
      pbuf_wa  = r_q.idx[5:0];
      pbuf_wd  = ERASED_WORD;
      ebuf_we  = 1'b0;
      ebuf_wa  = r_q.idx[1:0];
      ebuf_wd  = ERASED_BYTE;
      case (r_q.state)
         ST_OFF:
         begin
            r_d.cmd = CMD_NONE;
            if (ev.hv)
            begin
               if ({ev.sel_first, ev.act1, ev.act0, ev.wr_n} == ENTRY_PATTERN)
               begin
                  r_d.state = ST_CHECK;
                  r_d.cnt   = 16'h0000;
               end
               else
                  r_d.state = ST_FAIL;
            end
         end
         ST_CHECK:
         begin
            // Any wiggle on the pattern pins during the hold window spoils entry.
            if (!ev.hv)
               r_d.state = ST_OFF;
            else if ({ev.sel_first, ev.act1, ev.act0, ev.wr_n} != ENTRY_PATTERN)
               r_d.state = ST_FAIL;
            else if (r_q.cnt == ENTRY_HOLD_LAST)
               r_d.state = ST_READY;
            else
               r_d.cnt = r_q.cnt + 16'h0001;
         end
         ST_READY:
         begin
            if (!ev.hv)
               r_d.state = ST_OFF;
            else
            begin
               if (ev.load_rise)
               begin
                  case ({ev.act1, ev.act0})
                     ACT_ADDR:
                        if (ev.sel_first)
                           r_d.addr_hi = ev.data;
                        else
                           r_d.addr_lo = ev.data;
                     ACT_DATA:
                        if (ev.sel_first)
                           r_d.data_hi = ev.data;
                        else
                           r_d.data_lo = ev.data;
                     ACT_CMD:
                        r_d.cmd = ev.data;
                     default:
                        r_d.cmd = r_q.cmd;
                  endcase
               end
               if (ev.page_latch_strobe_rise && ev.sel_first && r_q.cmd == CMD_WRITE_FLASH)
               begin
                  pbuf_we = 1'b1;
                  pbuf_wa = cur_word[5:0];
                  pbuf_wd = {r_q.data_hi, r_q.data_lo};
               end
               if (ev.page_latch_strobe_rise && r_q.cmd == CMD_WRITE_EEPROM)
               begin
                  ebuf_we = 1'b1;
                  ebuf_wa = cur_ee[1:0];
                  ebuf_wd = r_q.data_lo;
               end
               if (ev.wr_fall)
               begin
                  r_d.idx      = 13'h0000;
                  r_d.cnt      = 16'h0000;
                  r_d.sweeping = 1'b0;
                  case (r_q.cmd)
                     CMD_CHIP_ERASE:
                     begin
                        r_d.state    = ST_BUSY;
                        r_d.sweeping = 1'b1;
                        r_d.last     = FLASH_LAST_WORD;
                     end
                     CMD_WRITE_FUSE:
                     begin
                        r_d.state = ST_BUSY;
                        if (write_ok)
                        begin
                           if (ev.act1)
                              r_d.fuse_ext = r_q.data_lo;
                           else if (ev.sel_first)
                              r_d.fuse_high = r_q.data_lo;
                           else
                              r_d.fuse_low = r_q.data_lo;
                        end
                     end
                     CMD_WRITE_LOCK:
                     begin
                        // Lock bits only ever program here; erase is the way back.
                        r_d.state = ST_BUSY;
                        r_d.lock  = r_q.lock & (r_q.data_lo | LOCK_KEEP_MASK);
                     end
                     CMD_WRITE_FLASH:
                        if (write_ok)
                        begin
                           r_d.state    = ST_BUSY;
                           r_d.sweeping = 1'b1;
                           r_d.last     = PAGE_LAST_WORD;
                        end
                     CMD_WRITE_EEPROM:
                        if (write_ok)
                        begin
                           r_d.state    = ST_BUSY;
                           r_d.sweeping = 1'b1;
                           r_d.last     = EE_PAGE_LAST;
                        end
                     default:
                        r_d.state = ST_READY;
                  endcase
               end
            end
         end
         ST_BUSY:
         begin
            // Strobes and loads are not looked at here, so the command stays put.
            if (!ev.hv)
               r_d.state = ST_OFF;
            else if (r_q.sweeping)
            begin
               if (r_q.cmd == CMD_CHIP_ERASE)
               begin
                  flash_we = 1'b1;
                  ee_we    = (r_q.idx <= EE_LAST_BYTE) && !keep_ee;
               end
               else if (r_q.cmd == CMD_WRITE_FLASH)
               begin
                  // Whole page written in one busy period from the buffer.
                  flash_we = 1'b1;
                  flash_wa = {cur_word[12:6], r_q.idx[5:0]};
                  flash_wd = page_buf[r_q.idx[5:0]];
                  pbuf_we  = 1'b1;
               end
               else
               begin
                  ee_we   = 1'b1;
                  ee_wa   = {cur_ee[8:2], r_q.idx[1:0]};
                  ee_wd   = ee_buf[r_q.idx[1:0]];
                  ebuf_we = 1'b1;
               end
               if (r_q.idx == r_q.last)
               begin
                  r_d.sweeping = 1'b0;
                  if (r_q.cmd == CMD_CHIP_ERASE)
                     r_d.lock = LOCK_RESET;
               end
               else
                  r_d.idx = r_q.idx + 13'h0001;
            end
            else if (r_q.cnt == BUSY_HOLD_LAST)
               r_d.state = ST_READY;
            else
               r_d.cnt = r_q.cnt + 16'h0001;
         end
         ST_FAIL:
            if (!ev.hv)
               r_d.state = ST_OFF;
         default:
            r_d.state = ST_OFF;
      endcase
      // The bus is driven only in programming mode with output enable low.
      r_d.rd_oe   = in_mode && !ev.oe_n;
      r_d.rd_data = rd_byte;
      r_d.ready   = (r_d.state != ST_BUSY);
   end

   // Memory ports; unused outside programming mode.
   always_ff @(posedge clock)
   begin
      if (enable)
      begin
         if (flash_we)
            flash_mem[flash_wa] <= flash_wd;
         if (ee_we)
            ee_mem[ee_wa] <= ee_wd;
         if (pbuf_we)
            page_buf[pbuf_wa] <= pbuf_wd;
         if (ebuf_we)
            ee_buf[ebuf_wa] <= ebuf_wd;
      end
   end

   // Control state register; command and address persist between operations.
   always_ff @(posedge clock)
   begin
      if (reset)
         r_q <= CORE_RESET;
      else if (enable)
         r_q <= r_d;
   end

   assign data_out         = r_q.rd_data;
   assign data_oe          = r_q.rd_oe;
   assign ready_busy_flag  = r_q.ready;
   assign prog_mode        = in_mode;
   assign entry_failed     = (r_q.state == ST_FAIL);
   assign eeprom_keep_fuse = keep_ee;
endmodule

//--- parallel_program_port_props.sv
`timescale 1ns/100ps
module parallel_program_port_props
   import prog_pkg::*;
(
   // Clock, reset and pins.
   input logic clock,
   input logic reset,
   input logic write_strobe_n,
   input logic output_enable_n,
   input logic high_voltage_entry,
   // Answers and status.
   input logic data_oe,
   input logic ready_busy_flag,
   input logic prog_mode,
   input logic entry_failed
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Pins pass a two-stage synchroniser, hence the three-clock lags below.
   oe_cause_a: assert property (data_oe |-> !$past(output_enable_n, 3))
      else $error("bus driven without enable");
   oe_drive_a: assert property (prog_mode && !$past(output_enable_n, 3) |-> data_oe)
      else $error("bus not driven");
   idle_ready_a: assert property (!$past(prog_mode) |-> ready_busy_flag)
      else $error("busy outside programming");
   hv_off_a: assert property (!$past(high_voltage_entry, 3) |-> !prog_mode)
      else $error("mode without entry voltage");
   entry_wait_a: assert property ($rose(prog_mode) |-> $past(high_voltage_entry, 15))
      else $error("entry too early");
   fail_excl_a: assert property (entry_failed |-> !prog_mode && ready_busy_flag)
      else $error("failed entry still active");
   busy_cause_a: assert property ($fell(ready_busy_flag) |-> !$past(write_strobe_n, 3))
      else $error("busy without write strobe");
   busy_len_a: assert property ($fell(ready_busy_flag) |-> !ready_busy_flag [*8])
      else $error("busy too short");
endmodule
bind parallel_program_port parallel_program_port_props props (.*);

//--- parallel_program_port_tb.sv
`timescale 1ns/100ps
module parallel_program_port_tb;
   import prog_pkg::*;
   logic  clock;
   logic  reset;
   logic  lcp, act0, act1, pl, wr_n, oe_n, hv, data_oe, rdy, prog_mode, failed, keep;
   byte_t pdata, data_in, data_out, q;
   byte_t sig [4] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2, CALIB_BYTE};
   byte_t fz [4] = '{FUSE_LOW_RESET, LOCK_RESET, FUSE_EXT_RESET, FUSE_HIGH_RESET};
   int    n_fail = 0;
   int    n_compared = 0;
   int    busy;
   // With nobody driving, the bus shows the inverse so stale data cannot pass.
   assign data_in = data_oe ? data_out : (oe_n ? pdata : ~pdata);
   // Free-running system clock.
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   parallel_program_port DUT (
      .clock(clock), .reset(reset), .enable(1'b1), .load_clock_pin(lcp),
      .load_action_bit0(act0), .load_action_bit1(act1), .page_latch_strobe(pl),
      .write_strobe_n(wr_n), .output_enable_n(oe_n), .high_voltage_entry(hv),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(rdy),
      .prog_mode(prog_mode), .entry_failed(failed), .eeprom_keep_fuse(keep));
   pin_programmer p (
      .clock(clock), .ready_busy_flag(rdy), .bus(data_in), .lcp(lcp), .act0(act0),
      .act1(act1), .pl(pl), .wr_n(wr_n), .oe_n(oe_n), .hv(hv), .pdata(pdata));
   // Four-state comparison, so an unknown never matches.
   task automatic cmp(input byte_t got, input byte_t exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic sel1, input logic sel2, input byte_t exp);
      p.read(sel1, sel2, q);
      cmp(q, exp);
   endtask
   // Busy length must fall in a window; zero means the strobe was ignored.
   task automatic op(input int lo, input int hi);
      p.strobe(busy);
      cmp({7'h00, busy >= lo && busy <= hi}, 8'h01);
   endtask
   task automatic test_done();
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // A hung handshake ends the run as a failure.
   initial
   begin
      repeat (90000) @(posedge clock);
      n_fail++;
      test_done();
   end
   // Main sequence.
   initial
   begin
      reset = 1'b1;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      p.enter(1'b1);
      p.load(2'h2, 1'b0, CMD_CHIP_ERASE);
      op(0, 0);
      cmp({6'h00, failed, prog_mode}, 8'h02);
      p.enter(1'b0);
      cmp({6'h00, keep, prog_mode}, 8'h01);
      p.load(2'h2, 1'b0, CMD_READ_SIG);
      for (int i = 0; i < 4; i++)
      begin
         p.load(2'h0, 1'b0, 8'(i % 3));
         rd(i == 3, 1'b0, sig[i]);
      end
      p.load(2'h2, 1'b0, CMD_READ_FUSE);
      for (int i = 0; i < 4; i++)
         rd(i[0], i[1], fz[i]);
      p.load(2'h3, 1'b0, CMD_CHIP_ERASE);
      op(0, 0);
      p.load(2'h2, 1'b0, CMD_CHIP_ERASE);
      op(8256, 8262);
      p.load(2'h2, 1'b0, CMD_WRITE_FLASH);
      p.load(2'h0, 1'b1, 8'h01);
      for (int i = 0; i < 64; i++)
      begin
         p.load(2'h0, 1'b0, 8'h40 | 8'(i));
         p.load(2'h1, 1'b0, 8'(i));
         p.load(2'h1, 1'b1, ~8'(i));
         p.latch();
      end
      op(128, 132);
      p.load(2'h2, 1'b0, CMD_READ_FLASH);
      for (int i = 0; i < 64; i += 21)
      begin
         p.load(2'h0, 1'b0, 8'h40 | 8'(i));
         rd(1'b0, 1'b0, 8'(i));
         rd(1'b1, 1'b0, ~8'(i));
      end
      p.load(2'h0, 1'b0, 8'h00);
      rd(1'b0, 1'b0, ERASED_BYTE);
      p.load(2'h2, 1'b0, CMD_WRITE_EEPROM);
      for (int i = 0; i < 4; i++)
      begin
         p.load(2'h0, 1'b0, 8'h04 + 8'(i));
         p.load(2'h1, 1'b0, 8'ha0 + 8'(i));
         p.latch();
      end
      p.load(2'h3, 1'b0, 8'h00);
      op(68, 72);
      p.load(2'h2, 1'b0, CMD_READ_EEPROM);
      for (int i = 0; i < 5; i++)
      begin
         p.load(2'h0, 1'b0, 8'h04 + 8'(i));
         rd(1'b0, 1'b0, i < 4 ? 8'ha0 + 8'(i) : ERASED_BYTE);
      end
      p.load(2'h2, 1'b0, CMD_WRITE_FUSE);
      p.load(2'h1, 1'b0, 8'hd7);
      p.latch();
      op(64, 67);
      cmp({7'h00, keep}, 8'h01);
      p.load(2'h2, 1'b0, CMD_WRITE_LOCK);
      p.load(2'h1, 1'b0, 8'hfc);
      op(64, 67);
      p.load(2'h2, 1'b0, CMD_READ_FUSE);
      rd(1'b1, 1'b0, 8'hfc);
      p.load(2'h2, 1'b0, CMD_CHIP_ERASE);
      op(8256, 8262);
      p.load(2'h2, 1'b0, CMD_READ_FUSE);
      rd(1'b1, 1'b1, 8'hd7);
      rd(1'b1, 1'b0, LOCK_RESET);
      p.load(2'h2, 1'b0, CMD_READ_EEPROM);
      p.load(2'h0, 1'b0, 8'h04);
      rd(1'b0, 1'b0, 8'ha0);
      p.load(2'h2, 1'b0, CMD_READ_FLASH);
      p.load(2'h0, 1'b0, 8'h40);
      rd(1'b0, 1'b0, ERASED_BYTE);
      test_done();
   end
endmodule

//--- pin_events_if.sv
`timescale 1ns/100ps
interface pin_events_if;
   import prog_pkg::*;
   byte_t data;
   logic  act0;
   logic  act1;
   logic  sel_first;
   logic  wr_n;
   logic  oe_n;
   logic  hv;
   logic  load_rise;
   logic  wr_fall;
   logic  page_latch_strobe_rise;

   modport sampler (output data, act0, act1, sel_first, wr_n, oe_n, hv,
                    load_rise, wr_fall, page_latch_strobe_rise);
   modport core    (input  data, act0, act1, sel_first, wr_n, oe_n, hv,
                    load_rise, wr_fall, page_latch_strobe_rise);
endinterface

//--- pin_programmer.sv
`timescale 1ns/100ps
module pin_programmer
   import prog_pkg::*;
(
   // Clock and device answers.
   input  logic            clock,
   input  logic            ready_busy_flag,
   input  prog_pkg::byte_t bus,
   // Programming pins.
   output logic            lcp,
   output logic            act0,
   output logic            act1,
   output logic            pl,
   output logic            wr_n,
   output logic            oe_n,
   output logic            hv,
   output prog_pkg::byte_t pdata
);
   // Strobes idle inactive and the entry voltage starts off.
   initial {lcp, act0, act1, pl, wr_n, oe_n, hv, pdata} = 15'h0600;
   task automatic w(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Levels stand 32 clocks, so each pulse is 256 ns, just over the minimum.
   task automatic load(input logic [1:0] act, input logic bs, input byte_t d);
      {act1, act0, pl, pdata} <= {act, bs, d};
      w(32);
      lcp <= 1'b1;
      w(32);
      lcp <= 1'b0;
      w(32);
   endtask
   // The latch pin is also byte select one, so it drops first to give a rising edge.
   task automatic latch();
      pl <= 1'b0;
      w(32);
      pl <= 1'b1;
      w(32);
   endtask
   // Nothing else is strobed until ready returns; busy counts the low clocks.
   task automatic strobe(output int busy);
      busy = 0;
      for (int i = 0; i < 9000 && !(ready_busy_flag && i > 40); i++)
      begin
         wr_n <= (i >= 32);
         @(posedge clock);
         busy += int'(!ready_busy_flag);
      end
   endtask
   // The bus is released while output enable is low.
   task automatic read(input logic sel1, input logic sel2, output byte_t q);
      {pl, act1, oe_n} <= {sel1, sel2, 1'b0};
      w(8);
      q = bus;
      oe_n <= 1'b1;
      w(8);
   endtask
   // The pattern, six load clocks with no entry voltage, then the voltage.
   task automatic enter(input logic spoil);
      {hv, pl, act1, act0, wr_n} <= 5'h00;
      repeat (12)
      begin
         w(8);
         lcp <= ~lcp;
      end
      w(16);
      hv <= 1'b1;
      w(4);
      act0 <= spoil;
      w(6250);
      wr_n <= 1'b1;
      w(32);
   endtask
endmodule

//--- pin_sampler.sv
`timescale 1ns/100ps
module pin_sampler
   import prog_pkg::*;
(
   // Clock, reset and freeze.
   input  logic               clock,
   input  logic               reset,
   input  logic               enable,
   // Raw programming pins.
   input  logic               load_clock_pin,
   input  logic               load_action_bit0,
   input  logic               load_action_bit1,
   input  logic               page_latch_strobe,
   input  logic               write_strobe_n,
   input  logic               output_enable_n,
   input  logic               high_voltage_entry,
   input  prog_pkg::byte_t    data_in,
   // Sampled levels and edges.
   pin_events_if.sampler      ev
);
   typedef struct packed {
      logic [14:0] sync1;
      logic [14:0] sync2;
      logic [2:0]  prev;
   } sampler_t;

   sampler_t r_q;
   sampler_t r_d;

   // Every pin passes two flops; edges are found on the second stage only.
   always_comb
   begin
      r_d = r_q;
      r_d.sync1 = {high_voltage_entry, output_enable_n, write_strobe_n, page_latch_strobe,
                   load_action_bit1, load_action_bit0, load_clock_pin, data_in};
      r_d.sync2 = r_q.sync1;
      r_d.prev  = {r_q.sync2[11], r_q.sync2[12], r_q.sync2[8]};
   end

   // Reset values match the idle pins, so no false edge follows reset.
   always_ff @(posedge clock)
   begin
      if (reset)
         r_q <= '{sync1: 15'h3000, sync2: 15'h3000, prev: 3'h2};
      else if (enable)
         r_q <= r_d;
   end

   // Edge pulses last one clock; a frozen core holds them too, so none is lost.
   assign ev.data       = r_q.sync2[7:0];
   assign ev.act0       = r_q.sync2[9];
   assign ev.act1       = r_q.sync2[10];
   assign ev.sel_first  = r_q.sync2[11];
   assign ev.wr_n       = r_q.sync2[12];
   assign ev.oe_n       = r_q.sync2[13];
   assign ev.hv         = r_q.sync2[14];
   assign ev.load_rise  = r_q.sync2[8] & ~r_q.prev[0];
   assign ev.wr_fall    = ~r_q.sync2[12] & r_q.prev[1];
   assign ev.page_latch_strobe_rise = r_q.sync2[11] & ~r_q.prev[2];
endmodule

//--- prog_pkg.sv
package prog_pkg;

   typedef logic [7:0]  byte_t;
   typedef logic [15:0] word_t;

   // Memory geometry.
   localparam int FLASH_AW      = 13;
   localparam int PAGE_WORD_W   = 6;
   localparam int EE_AW         = 9;
   localparam int EE_PAGE_BYTE_W = 2;
   localparam logic [12:0] FLASH_LAST_WORD = 13'h1fff;
   localparam logic [12:0] PAGE_LAST_WORD  = 13'h003f;
   localparam logic [12:0] EE_PAGE_LAST    = 13'h0003;
   localparam logic [12:0] EE_LAST_BYTE    = 13'h01ff;

   // Action bit codes sampled on the load clock edge.
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;

   // Command bytes.
   localparam byte_t CMD_CHIP_ERASE   = 8'h80;
   localparam byte_t CMD_WRITE_FUSE   = 8'h40;
   localparam byte_t CMD_WRITE_LOCK   = 8'h20;
   localparam byte_t CMD_WRITE_FLASH  = 8'h10;
   localparam byte_t CMD_WRITE_EEPROM = 8'h11;
   localparam byte_t CMD_READ_SIG     = 8'h08;
   localparam byte_t CMD_READ_FUSE    = 8'h04;
   localparam byte_t CMD_READ_FLASH   = 8'h02;
   localparam byte_t CMD_READ_EEPROM  = 8'h03;
   localparam byte_t CMD_NONE         = 8'h00;

   // Fuse and lock reset values; a zero bit means programmed.
   localparam byte_t FUSE_LOW_RESET  = 8'h62;
   localparam byte_t FUSE_HIGH_RESET = 8'hdf;
   localparam byte_t FUSE_EXT_RESET  = 8'hff;
   localparam byte_t LOCK_RESET      = 8'hff;
   localparam byte_t LOCK_KEEP_MASK  = 8'hfc;
   localparam int    KEEP_FUSE_BIT   = 3;
   localparam logic [1:0] LOCK_MODE_OPEN = 2'h3;
   localparam logic [1:0] LOCK_MODE_FULL = 2'h0;

   // Identity bytes; these values are arbitrary.
   localparam byte_t SIG_BYTE0  = 8'h5a;
   localparam byte_t SIG_BYTE1  = 8'h21;
   localparam byte_t SIG_BYTE2  = 8'h43;
   localparam byte_t CALIB_BYTE = 8'h80;

   localparam byte_t ERASED_BYTE = 8'hff;
   localparam word_t ERASED_WORD = 16'hffff;
   localparam logic [3:0] ENTRY_PATTERN = 4'h0;

   // Timing.
   localparam int CLOCK_PERIOD_NS   = 8;
   localparam int ENTRY_HOLD_NS     = 100;
   localparam int ENTRY_HOLD_CYCLES = (ENTRY_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [15:0] ENTRY_HOLD_LAST = 16'(ENTRY_HOLD_CYCLES - 1);
   localparam logic [15:0] BUSY_HOLD_LAST  = 16'h003f;

   // Programming state, Gray coded along off, check, ready, busy.
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_CHECK = 3'b001,
      ST_READY = 3'b011,
      ST_BUSY  = 3'b010,
      ST_FAIL  = 3'b110
   } prog_state_t;

endpackage
